// File: rtl/spms_pkg.sv
package spms_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;

  // Status bit positions; the two sticky event bits share the layout of the enable and clear registers.
  localparam int ST_DONE = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_BUSY = 2;
  localparam int N_EVENTS = 2;

  // Control fields, bit 0 first: port_enable, master_select, select_pin_disable, select_output_enable.
  typedef struct packed {
    logic select_output_enable;
    logic select_pin_disable;
    logic master_select;
    logic port_enable;
  } spms_ctrl_t;

  // Reset values.
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Serial clock timing.
  localparam int SYS_CLK_HZ = 50000000;
  localparam int SCK_HZ = 6250000;
  localparam int HALF_CYC = SYS_CLK_HZ / (2 * SCK_HZ);
  localparam int BITS = 8;

  // Master engine states.
  typedef enum logic [2:0] {
    SPMS_IDLE = 3'b001,
    SPMS_LOWH = 3'b010,
    SPMS_HIGH = 3'b100
  } spms_state_t;

endpackage

// File: rtl/spms_top.sv
`timescale 1ns/1ps
`default_nettype none

module spms_top #(
  parameter int HALF_CYC = spms_pkg::HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_in,
  output logic ss_out,
  output logic ss_oe
);

  // Cycles from the start edge until done: sixteen half periods plus the cycle that loads the first bit.
  localparam int XFER_CYC = 2 * spms_pkg::BITS * HALF_CYC + 1;

  spms_pkg::spms_ctrl_t ctrl;
  spms_pkg::spms_state_t state;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sck_d;
  logic ss_d;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] shift_reg;
  logic [2:0] bitcnt;
  logic [7:0] div;
  logic done;
  logic [spms_pkg::N_EVENTS-1:0] sticky;
  logic [spms_pkg::N_EVENTS-1:0] irq_en;
  logic [spms_pkg::N_EVENTS-1:0] next_sticky;

  // Synchronised pin levels and edges; only second-stage flops are read by logic.
  wire logic sck_s = sync2[3];
  wire logic mosi_s = sync2[2];
  wire logic miso_s = sync2[1];
  wire logic ss_s = sync2[0];
  wire logic sck_rise = sck_s && !sck_d;
  wire logic sck_fall = !sck_s && sck_d;
  wire logic ss_fall = !ss_s && ss_d;

  wire logic acc = hsel && htrans[1] && hready;
  wire logic wr_ctrl = wr_en && (wr_addr == spms_pkg::OFF_CTRL);
  wire logic wr_data = wr_en && (wr_addr == spms_pkg::OFF_DATA);
  wire logic wr_ien = wr_en && (wr_addr == spms_pkg::OFF_IRQ_EN);
  wire logic wr_clr = wr_en && (wr_addr == spms_pkg::OFF_IRQ_CLR);
  wire logic busy = (state != spms_pkg::SPMS_IDLE);

  // Watched select input.
  // The reserved disable-0 output-enable-1 combination neither watches nor drives the pin.
  wire logic watch_ss = ctrl.port_enable && ctrl.master_select && !ctrl.select_pin_disable &&
                        !ctrl.select_output_enable;
  // No disabled faults.
  // A set disable bit keeps watch_ss low, so neither the general-purpose nor the output setting can fault.
  // Fault on low select.
  wire logic fault = watch_ss && !ss_s;
  wire logic m_start = wr_data && ctrl.port_enable && ctrl.master_select && !busy;

  // Two-flop synchronisers for all four serial pins, sampled on the system clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // The clock stage resets to its idle low level so that no false edge follows reset.
      sync1 <= 4'h7;
      sync2 <= 4'h7;
      sck_d <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      sync1 <= {sck_in, mosi_in, miso_in, ss_in};
      sync2 <= sync1;
      sck_d <= sck_s;
      ss_d <= ss_s;
    end
  end

  // AHB-Lite address phase capture; the slave never inserts wait states and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_en <= acc && hwrite;
      wr_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is registered at the end of the address phase so it stands during the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      unique case (haddr[7:0])
        spms_pkg::OFF_CTRL: hrdata <= {28'h0, ctrl};
        spms_pkg::OFF_DATA: hrdata <= {24'h0, rx_data};
        spms_pkg::OFF_STATUS: hrdata <= {29'h0, busy, sticky};
        spms_pkg::OFF_IRQ_EN: hrdata <= {30'h0, irq_en};
        default: hrdata <= 32'h0;
      endcase
    end else begin
      hrdata <= 32'h0;
    end
  end

  // Control register; a mode fault overrides a software write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= spms_pkg::spms_ctrl_t'(spms_pkg::CTRL_RST);
    end else if (fault) begin
      ctrl.master_select <= 1'b0;
      ctrl.port_enable <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl <= spms_pkg::spms_ctrl_t'(hwdata[3:0]);
    end
  end

  // Transmit byte; in slave role it waits here until the external master selects us.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data <= spms_pkg::DATA_RST;
    end else if (wr_data) begin
      tx_data <= hwdata[7:0];
    end
  end

  // Shift engine for both roles. A write while busy only updates the transmit byte.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= spms_pkg::SPMS_IDLE;
      shift_reg <= spms_pkg::DATA_RST;
      rx_data <= spms_pkg::DATA_RST;
      bitcnt <= 3'h0;
      div <= 8'h00;
      done <= 1'b0;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      ss_oe <= 1'b0;
      ss_out <= 1'b0;
    end else if (!ctrl.port_enable || fault) begin
      // Disabled port idles.
      // Only the engine is parked; the shift and receive bytes keep their values for software.
      state <= spms_pkg::SPMS_IDLE;
      done <= 1'b0;
      sck_out <= 1'b0;
      ss_oe <= 1'b0;
    end else if (ctrl.master_select) begin
      done <= 1'b0;
      unique case (state)
        spms_pkg::SPMS_IDLE: begin
          if (m_start) begin
            shift_reg <= hwdata[7:0];
            mosi_out <= hwdata[7];
            bitcnt <= 3'h0;
            div <= 8'h00;
            ss_oe <= ctrl.select_pin_disable && ctrl.select_output_enable;
            state <= spms_pkg::SPMS_LOWH;
          end
        end
        spms_pkg::SPMS_LOWH: begin
          // The sample below uses the synchronised MISO, two cycles old; half a period of margin covers it.
          // Limitation: HALF_CYC below 3 leaves too little margin for that synchroniser delay.
          if (div == 8'(HALF_CYC - 1)) begin
            div <= 8'h00;
            sck_out <= 1'b1;
            shift_reg <= {shift_reg[6:0], miso_s};
            state <= spms_pkg::SPMS_HIGH;
          end else begin
            div <= div + 8'h01;
          end
        end
        spms_pkg::SPMS_HIGH: begin
          if (div == 8'(HALF_CYC - 1)) begin
            div <= 8'h00;
            sck_out <= 1'b0;
            if (bitcnt == 3'(spms_pkg::BITS - 1)) begin
              rx_data <= shift_reg;
              done <= 1'b1;
              ss_oe <= 1'b0;
              state <= spms_pkg::SPMS_IDLE;
            end else begin
              bitcnt <= bitcnt + 3'h1;
              mosi_out <= shift_reg[7];
              state <= spms_pkg::SPMS_LOWH;
            end
          end else begin
            div <= div + 8'h01;
          end
        end
      endcase
    end else begin
      state <= spms_pkg::SPMS_IDLE;
      sck_out <= 1'b0;
      ss_oe <= 1'b0;
      done <= 1'b0;
      if (ss_fall) begin
        shift_reg <= tx_data;
        miso_out <= tx_data[7];
        bitcnt <= 3'h0;
      end else if (!ss_s && sck_rise) begin
        shift_reg <= {shift_reg[6:0], mosi_s};
        bitcnt <= bitcnt + 3'h1;
        if (bitcnt == 3'(spms_pkg::BITS - 1)) begin
          rx_data <= {shift_reg[6:0], mosi_s};
          done <= 1'b1;
        end
      end else if (!ss_s && sck_fall) begin
        miso_out <= shift_reg[7];
      end
    end
  end

  // Pin drive enables. Select keeps quasi-bidirectional drive: it is only ever pulled low actively.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_oe <= ctrl.port_enable && ctrl.master_select;
      mosi_oe <= ctrl.port_enable && ctrl.master_select;
      miso_oe <= ctrl.port_enable && !ctrl.master_select && !ss_s;
    end
  end

  // Sticky event flags.
  // Set wins over a clear in the same cycle so no event is lost.
  always_comb begin
    next_sticky = sticky;
    if (wr_clr) begin
      next_sticky = next_sticky & ~hwdata[spms_pkg::N_EVENTS-1:0];
    end
    next_sticky[spms_pkg::ST_DONE] = next_sticky[spms_pkg::ST_DONE] | done;
    next_sticky[spms_pkg::ST_FAULT] = next_sticky[spms_pkg::ST_FAULT] | fault;
  end

  // Event flags, enables and the level interrupt output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky <= '0;
      irq_en <= spms_pkg::IRQ_EN_RST;
      irq <= 1'b0;
    end else begin
      sticky <= next_sticky;
      if (wr_ien) begin
        irq_en <= hwdata[spms_pkg::N_EVENTS-1:0];
      end
      // The output lags the flags by one cycle because it is registered like every top-level output.
      // Enabled events interrupt.
      irq <= |(sticky & irq_en);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_launch;
    m_start && ctrl.select_pin_disable;
  endsequence

  sequence s_complete;
    ##XFER_CYC done;
  endsequence

  a_fault_clears_mode: assert property (fault |=> !ctrl.port_enable && !ctrl.master_select)
    else $error("Mode fault did not clear enable and master bits.");
  a_fault_sets_flag: assert property (fault |=> sticky[spms_pkg::ST_FAULT])
    else $error("Mode fault flag not set.");
  a_irq_follows_flag: assert property ((|(sticky & irq_en)) [*2] |-> irq)
    else $error("Interrupt not raised for enabled flag.");
  a_disabled_pins_free: assert property (!ctrl.port_enable |=> !sck_oe && !mosi_oe && !miso_oe && !ss_oe)
    else $error("Disabled port still drives a pin.");
  a_slave_ss_input: assert property (!ctrl.master_select |=> !ss_oe)
    else $error("Slave drives the select pin.");
  a_miso_when_selected: assert property (miso_oe |-> $past(!ss_s) && $past(!ctrl.master_select))
    else $error("MISO driven while not selected.");
  a_mosi_leads_clock: assert property ($rose(sck_out) |-> mosi_out == $past(mosi_out, 3))
    else $error("MOSI changed within half a clock before the sampling edge.");
  a_eight_bit_xfer: assert property (s_launch |-> s_complete)
    else $error("Master byte exchange did not finish after eight bits.");
  a_select_held_low: assert property (busy && ss_oe |=> ss_oe || done)
    else $error("Select released before the exchange ended.");
  a_no_fault_disabled: assert property (ctrl.port_enable && ctrl.select_pin_disable && !wr_ctrl |=>
    ctrl.port_enable)
    else $error("Mode fault raised with select disable set.");

  // A watched master sees its select pin low, the first step of a mode fault.
  sequence s_select_seen_low;
    ctrl.port_enable && ctrl.master_select && !ctrl.select_pin_disable &&
    !ctrl.select_output_enable && !ss_s;
  endsequence

  // The fault has been handled: the role and enable bits are gone and the flag stands.
  sequence s_fault_handled;
    ##1 !ctrl.master_select && !ctrl.port_enable && sticky[spms_pkg::ST_FAULT];
  endsequence

  // These watch control bits, pins and flags rather than the decode terms, so a broken decode still trips them.
  a_watched_low_faults: assert property (s_select_seen_low |-> s_fault_handled)
    else $error("Low select in watched master role did not cause a mode fault.");
  a_slave_stays_idle: assert property (!ctrl.master_select |=> state == spms_pkg::SPMS_IDLE)
    else $error("Slave role started a transfer.");
  a_master_pins_driven: assert property (ctrl.port_enable && ctrl.master_select |=>
    sck_oe && mosi_oe && !miso_oe)
    else $error("Master role does not drive clock and MOSI.");
  a_gpio_select_free: assert property (!busy && ctrl.select_pin_disable && !ctrl.select_output_enable |=>
    !ss_oe)
    else $error("Select pin driven while it is a general-purpose pin.");
  a_select_only_low: assert property (ss_oe |-> !ss_out)
    else $error("Select pin driven high instead of released.");
  a_clock_idle_low: assert property (!busy |-> !sck_out)
    else $error("Serial clock not low while idle.");
  a_done_single_pulse: assert property (done |=> !done)
    else $error("Completion pulse lasted more than one cycle.");
  a_done_sets_flag: assert property (done |=> sticky[spms_pkg::ST_DONE])
    else $error("Completed exchange did not set its flag.");

endmodule

`default_nettype wire

// File: test/spms_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spms_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n,
  input wire logic go,
  input wire logic [7:0] m_tx,
  input wire logic [7:0] s_tx,
  output logic m_sck,
  output logic m_mosi,
  output logic m_oe,
  output logic m_ss_low,
  output logic s_miso,
  output logic s_oe,
  output logic [7:0] m_rx,
  output logic [7:0] s_rx
);
  logic [7:0] sh;
  // Everything idle and released at time zero.
  initial begin
    {m_sck, m_mosi, m_oe, m_ss_low, s_miso, s_oe} = 6'h0;
    {m_rx, s_rx, sh} = 24'h0;
  end
  // select held low
  // Far-side master: the 7 ns lag keeps its edges off the system clock edges.
  always @(posedge go) begin
    #7;
    m_ss_low = 1'h1;
    m_oe = 1'h1;
    m_mosi = m_tx[7];
    #160;
    for (int i = 6; i >= -1; i--) begin
      m_sck = 1'h1;
      m_rx = {m_rx[6:0], miso};
      #80;
      m_sck = 1'h0;
      if (i >= 0) begin
        m_mosi = m_tx[i];
      end
      #80;
    end
    m_ss_low = 1'h0;
    m_oe = 1'h0;
  end
  // Far-side slave answers only while selected and while not acting as master.
  always @(negedge ss_n) begin
    if (!m_ss_low) begin
      sh = s_tx;
      s_miso = s_tx[7];
      s_oe = 1'h1;
    end
  end
  // Deselect releases the answer line.
  always @(posedge ss_n) begin
    s_oe = 1'h0;
  end
  // Sample on the rising edge, shift on the falling edge.
  always @(posedge sck) begin
    if (s_oe) begin
      s_rx = {s_rx[6:0], mosi};
    end
  end
  // Next bit goes out on the falling edge.
  always @(negedge sck) begin
    if (s_oe) begin
      sh = {sh[6:0], 1'h0};
      s_miso = sh[7];
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'h0;
  logic tb_ss_low = 1'h0;
  logic [7:0] m_tx = 8'h00;
  logic [7:0] s_tx = 8'h00;
  logic hreadyout, hresp, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
  logic m_sck, m_mosi, m_oe, m_ss_low, s_miso, s_oe;
  logic [7:0] m_rx, s_rx;
  logic [31:0] hrdata, r;
  int failures = 0;
  int num_checks = 0;
  // Rows: interrupt enable, byte sent, byte the far side returns.
  logic [17:0] rows [4] = '{18'h300FF, 18'h1FF00, 18'h0A55A, 18'h2817E};
  // Wire levels: select and answer line are pulled up, a released data line flips.
  wire logic sck = sck_oe ? sck_out : m_sck;
  wire logic mosi = mosi_oe ? mosi_out : (m_oe ? m_mosi : ~m_mosi);
  wire logic miso = miso_oe ? miso_out : (s_oe ? s_miso : 1'h1);
  wire logic ss_n = ss_oe ? ss_out : ~(m_ss_low | tb_ss_low);
  always #10 hclk = ~hclk;
  spms_top u_spms_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_in(ss_n), .ss_out(ss_out), .ss_oe(ss_oe));
  spms_peer u_spms_peer (.sck(sck), .mosi(mosi), .miso(miso), .ss_n(ss_n), .go(go), .m_tx(m_tx),
    .s_tx(s_tx), .m_sck(m_sck), .m_mosi(m_mosi), .m_oe(m_oe), .m_ss_low(m_ss_low), .s_miso(s_miso),
    .s_oe(s_oe), .m_rx(m_rx), .s_rx(s_rx));

  task automatic finish_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; entered just after a rising edge, read data lands in r.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    r = hrdata;
    if (hreadyout !== 1'h1) begin
      failures++;
      finish_test();
    end
  endtask

  // Pin enables are looked at mid-cycle, once the launching edge has settled.
  task automatic pins(input logic [3:0] e);
    @(negedge hclk);
    chk({28'h0, sck_oe, mosi_oe, miso_oe, ss_oe}, {28'h0, e});
    @(posedge hclk);
  endtask

  // Busy is polled through the status register; the far-side frame through its select.
  task automatic wait_for(input logic on_bus, input logic want);
    int n;
    n = 0;
    do begin
      if (on_bus) begin
        bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
      end else begin
        @(posedge hclk);
      end
      n++;
    end while ((on_bus ? r[spms_pkg::ST_BUSY] : m_ss_low) !== want && n < 300);
    if (n >= 300) begin
      failures++;
      finish_test();
    end
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'h0, spms_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, spms_pkg::OFF_IRQ_EN, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, 8'h40, 32'hFFFFFFFF);
    bus(1'h0, 8'h40, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, spms_pkg::OFF_DATA, 32'h5A);
    pins(4'h0);
    bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    bus(1'h1, spms_pkg::OFF_CTRL, 32'hF);
    // Master exchanges, one per row, with the done interrupt masked or not.
    for (int i = 0; i < 4; i++) begin
      s_tx <= rows[i][7:0];
      bus(1'h1, spms_pkg::OFF_IRQ_EN, {30'h0, rows[i][17:16]});
      bus(1'h1, spms_pkg::OFF_DATA, {24'h0, rows[i][15:8]});
      pins(4'hD);
      wait_for(1'h1, 1'h0);
      chk({24'h0, s_rx}, {24'h0, rows[i][15:8]});
      bus(1'h0, spms_pkg::OFF_DATA, 32'h0);
      chk(r, {24'h0, rows[i][7:0]});
      bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
      chk(r, 32'h1);
      chk({31'h0, irq}, {31'h0, rows[i][16]});
      bus(1'h1, spms_pkg::OFF_IRQ_CLR, 32'h3);
      bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Slave with both select settings set: select stays an input.
    bus(1'h1, spms_pkg::OFF_CTRL, 32'hD);
    bus(1'h1, spms_pkg::OFF_DATA, 32'h3C);
    pins(4'h0);
    bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    m_tx <= 8'hC5;
    go <= 1'h1;
    wait_for(1'h0, 1'h1);
    repeat (10) @(posedge hclk);
    pins(4'h2);
    wait_for(1'h0, 1'h0);
    go <= 1'h0;
    bus(1'h0, spms_pkg::OFF_DATA, 32'h0);
    chk(r, 32'hC5);
    chk({24'h0, m_rx}, 32'h3C);
    // Select low while a general-purpose pin, then while watched.
    bus(1'h1, spms_pkg::OFF_IRQ_CLR, 32'h3);
    bus(1'h1, spms_pkg::OFF_IRQ_EN, 32'h2);
    bus(1'h1, spms_pkg::OFF_CTRL, 32'h7);
    tb_ss_low <= 1'h1;
    // The pin enables follow a new control word one edge after it lands.
    @(posedge hclk);
    pins(4'hC);
    repeat (8) @(posedge hclk);
    bus(1'h0, spms_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'h7);
    bus(1'h1, spms_pkg::OFF_CTRL, 32'h3);
    repeat (8) @(posedge hclk);
    bus(1'h0, spms_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h2);
    chk({31'h0, irq}, 32'h1);
    tb_ss_low <= 1'h0;
    // Reset in mid-run: the port lets go of every pin and flags, enables and control start from zero.
    hresetn <= 1'h0;
    pins(4'h0);
    chk({31'h0, irq}, 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, spms_pkg::OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, spms_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
